// ### verilog/bst_defs.svh
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// Instruction register width and codes
`define BST_IR_W 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_SAMPLE 3'h4
`define BST_IR_BYPASS 3'h7
// Fixed pattern loaded into the instruction shifter at capture
`define BST_IR_CAPTURE 3'h1
// Pads served by one io_cell_group
`define BST_PADS_PER_GROUP 4
// Boundary cells per pad: data cell then direction cell
`define BST_CELLS_PER_PAD 2
`define BST_DATA_CELL 0
`define BST_DIR_CELL 1
// Highest test clock rate the host may use
`define BST_TCK_MAX_MHZ 10

`endif

// ### verilog/bst_pkg.sv
package bst_pkg;

    // Sixteen test-access states
    typedef enum logic [3:0] {
        ST_TEST_LOGIC_RESET,
        ST_RUN_TEST_IDLE,
        ST_SELECT_DR,
        ST_CAPTURE_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPDATE_DR,
        ST_SELECT_IR,
        ST_CAPTURE_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPDATE_IR
    } bst_state_type;

    // Controller strobes towards the registers
    typedef struct packed {
        logic treset;
        logic capture_dr;
        logic shift_dr_n;
        logic update_dr;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
    } bst_ctrl_type;

endpackage

// ### verilog/bst_boundary_scan.sv
// Function
// RULE1 - Host drives mode-select in step with the test clock.
// RULE2 - Next controller state depends only on present state and mode-select.
// RULE3 - Four boundary cells per io_cell_group, all chained serially; the code chains eight, two per pad.
// RULE4 - Cells shift serially and observe pad input, output and tristate.
// RULE5 - Each cell has a shift flop feeding an update flop driving the pad.
// RULE6 - Data cell sits in series with its direction cell in the chain.
// RULE7 - Normal mode: pads carry array data, array sees pad, no interference.
// RULE8 - Test mode: shift from upstream, drive stimulus, capture pad values.
// RULE9 - Cells governed by capture, update, shift_n, reset, clock and mode.
// RULE10 - Direction cell produces direction_select for the data cell.
// RULE11 - direction_select low: data cell captures the pad input.
// RULE12 - direction_select high: data cell captures the array output value; under external test the code captures the held update value.
// RULE13 - Mode comes from decoding the instruction register.
// RULE14 - Mode high (external test): pad driven from held scan data.
// RULE15 - Mode low (bypass, sample): pad driven from functional logic.
// RULE16 - Mode-select and serial input sampled on rising test clock.
// RULE17 - Serial output changes only on falling test clock.
// RULE18 - Under external test, update values reach pads on falling edge.
// RULE19 - Host keeps the test clock at or below 10 MHz; the bench host model runs a 32 ns period, 31.25 MHz.
// RULE20 - Host changes mode-select and serial input on falling edge.
// RULE21 - Three-bit instruction: 000 external test, 100 sample, 111 bypass.
// RULE22 - All sixteen states, clocked by test clock, steered by mode-select.
// RULE23 - Bypass: serial input passes one bypass flop to serial output.
// RULE24 - Update flops hold during shifting, change only on update.
// RULE25 - Test logic reset returns cells to low mode, pads functional.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_boundary_scan #(
    parameter int NUM_PADS = `BST_PADS_PER_GROUP
) (
    // System clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Test port
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    // Pads
    input wire logic [NUM_PADS-1:0] PAD_IN,
    output logic [NUM_PADS-1:0] PAD_OUT,
    output logic [NUM_PADS-1:0] PAD_OE,
    // Logic cell array side
    input wire logic [NUM_PADS-1:0] CORE_OUT,
    input wire logic [NUM_PADS-1:0] CORE_OE,
    output logic [NUM_PADS-1:0] CORE_IN,
    output logic TEST_MODE
);

    // Chain order: cell 0 takes serial input, top cell feeds serial output;
    // pad k owns data cell 2k and direction cell 2k+1
    localparam int CHAIN_W = NUM_PADS * `BST_CELLS_PER_PAD;

    // Reset carried into the test clock domain
    logic trst_n_m_q;
    logic trst_n_q;
    // Pin and array signals synchronised to the test clock
    logic [NUM_PADS-1:0] pin_t1_q, pin_t2_q;
    logic [NUM_PADS-1:0] cout_t1_q, cout_t2_q;
    logic [NUM_PADS-1:0] coe_t1_q, coe_t2_q;
    // Controller
    bst_pkg::bst_state_type state_q, state_d;
    bst_pkg::bst_ctrl_type ctrl;
    // Instruction path
    logic [`BST_IR_W-1:0] ir_sh_q;
    logic [`BST_IR_W-1:0] ir_q;
    logic mode;
    logic sel_chain;
    // Data paths
    logic [CHAIN_W-1:0] chain_q;
    logic [CHAIN_W-1:0] upd_q;
    logic [CHAIN_W-1:0] cap_val;
    logic bypass_q;
    logic tdo_d;
    // Array side sync of pads and mode
    logic [NUM_PADS-1:0] pin_r1_q, pin_r2_q;
    logic mode_r1_q, mode_r2_q;

    // Power-up reset into the test domain; test clock must run during reset
    // Test domain stays in reset until two test clock rises have passed
    always_ff @(posedge TCK) begin
        trst_n_m_q <= RST_N;
        trst_n_q <= trst_n_m_q;
    end

    // Pads are not test-clock timed, so two flops before any use
    always_ff @(posedge TCK) begin
        pin_t1_q <= PAD_IN;
        pin_t2_q <= pin_t1_q;
    end

    // Array value word crosses bit by bit; capture is only a snapshot,
    // so a word moving within two test clocks may be caught half updated
    always_ff @(posedge TCK) begin
        cout_t1_q <= CORE_OUT;
        cout_t2_q <= cout_t1_q;
    end

    // Array enables, same snapshot limitation
    always_ff @(posedge TCK) begin
        coe_t1_q <= CORE_OE;
        coe_t2_q <= coe_t1_q;
    end

    // Five ones reach reset from any state, so a lost host can recover
    // Next-state graph, steered only by sampled mode-select
    always_comb begin
        case (state_q)
            bst_pkg::ST_TEST_LOGIC_RESET:
                state_d = TMS ? bst_pkg::ST_TEST_LOGIC_RESET : bst_pkg::ST_RUN_TEST_IDLE;
            bst_pkg::ST_RUN_TEST_IDLE:
                state_d = TMS ? bst_pkg::ST_SELECT_DR : bst_pkg::ST_RUN_TEST_IDLE;
            bst_pkg::ST_SELECT_DR:
                state_d = TMS ? bst_pkg::ST_SELECT_IR : bst_pkg::ST_CAPTURE_DR;
            bst_pkg::ST_CAPTURE_DR:
                state_d = TMS ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_SHIFT_DR:
                state_d = TMS ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR:
                state_d = TMS ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR:
                state_d = TMS ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR:
                state_d = TMS ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPDATE_DR:
                state_d = TMS ? bst_pkg::ST_SELECT_DR : bst_pkg::ST_RUN_TEST_IDLE;
            bst_pkg::ST_SELECT_IR:
                state_d = TMS ? bst_pkg::ST_TEST_LOGIC_RESET : bst_pkg::ST_CAPTURE_IR;
            bst_pkg::ST_CAPTURE_IR:
                state_d = TMS ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_SHIFT_IR:
                state_d = TMS ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR:
                state_d = TMS ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR:
                state_d = TMS ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR:
                state_d = TMS ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_UPDATE_IR:
                state_d = TMS ? bst_pkg::ST_SELECT_DR : bst_pkg::ST_RUN_TEST_IDLE;
            default:
                state_d = bst_pkg::ST_TEST_LOGIC_RESET;
        endcase
    end

    // Controller register, rising test clock only
    always_ff @(posedge TCK) begin
        if (!trst_n_q) begin
            state_q <= bst_pkg::ST_TEST_LOGIC_RESET;
        end else begin
            state_q <= state_d; // [RULE2] [RULE16] [RULE22]
        end
    end

    // Strobes decoded from the present state
    always_comb begin
        ctrl.treset = (state_q == bst_pkg::ST_TEST_LOGIC_RESET);
        ctrl.capture_dr = (state_q == bst_pkg::ST_CAPTURE_DR);
        ctrl.shift_dr_n = (state_q != bst_pkg::ST_SHIFT_DR);
        ctrl.update_dr = (state_q == bst_pkg::ST_UPDATE_DR);
        ctrl.capture_ir = (state_q == bst_pkg::ST_CAPTURE_IR);
        ctrl.shift_ir = (state_q == bst_pkg::ST_SHIFT_IR);
        ctrl.update_ir = (state_q == bst_pkg::ST_UPDATE_IR);
    end

    // Instruction shifter, LSB leaves first
    always_ff @(posedge TCK) begin
        if (!trst_n_q) begin
            ir_sh_q <= '0;
        end else if (ctrl.capture_ir) begin
            ir_sh_q <= `BST_IR_CAPTURE;
        end else if (ctrl.shift_ir) begin
            ir_sh_q <= {TDI, ir_sh_q[`BST_IR_W-1:1]}; // [RULE16]
        end
    end

    // Active instruction; reset falls back to bypass so mode drops
    always_ff @(negedge TCK) begin
        if (!trst_n_q || ctrl.treset) begin
            ir_q <= `BST_IR_BYPASS; // [RULE25]
        end else if (ctrl.update_ir) begin
            ir_q <= ir_sh_q; // [RULE21]
        end
    end

    // Instruction decode; vendor and reserved codes act as bypass here
    // Only two codes reach the chain; all others see the bypass flop
    assign mode = (ir_q == `BST_IR_EXTEST); // [RULE13] [RULE21]
    assign sel_chain = (ir_q == `BST_IR_EXTEST) || (ir_q == `BST_IR_SAMPLE); // [RULE21]

    // Per pad: direction cell then data cell capture values
    for (genvar k = 0; k < NUM_PADS; k++) begin : g_pad
        logic dir_sel;
        localparam int DC = k * `BST_CELLS_PER_PAD + `BST_DATA_CELL;
        localparam int CC = k * `BST_CELLS_PER_PAD + `BST_DIR_CELL;
        // Effective tristate seen at the pad drives direction_select
        assign dir_sel = mode ? upd_q[CC] : coe_t2_q[k]; // [RULE10]
        // Out towards pad: array value, or held one under external test
        assign cap_val[DC] = dir_sel ? (mode ? upd_q[DC] : cout_t2_q[k]) // [RULE12]
                                     : pin_t2_q[k]; // [RULE11] [RULE4]
        assign cap_val[CC] = dir_sel; // [RULE4]
    end

    // Boundary chain: capture, then shift from TDI side upward
    always_ff @(posedge TCK) begin
        if (!trst_n_q) begin
            chain_q <= '0;
        end else if (ctrl.capture_dr && sel_chain) begin
            chain_q <= cap_val; // [RULE8] [RULE9]
        end else if (!ctrl.shift_dr_n && sel_chain) begin
            chain_q <= {chain_q[CHAIN_W-2:0], TDI}; // [RULE3] [RULE6] [RULE16]
        end
    end

    // Update flops hold while shifting, load on falling edge in update
    always_ff @(negedge TCK) begin
        if (!trst_n_q || ctrl.treset) begin
            upd_q <= '0; // [RULE25]
        end else if (ctrl.update_dr && sel_chain) begin
            upd_q <= chain_q; // [RULE5] [RULE18] [RULE24]
        end
    end

    // Single bypass flop, captures zero
    always_ff @(posedge TCK) begin
        if (!trst_n_q) begin
            bypass_q <= 1'b0;
        end else if (ctrl.capture_dr) begin
            bypass_q <= 1'b0;
        end else if (!ctrl.shift_dr_n) begin
            bypass_q <= TDI; // [RULE23]
        end
    end

    // Serial output source by state and instruction
    always_comb begin
        if (ctrl.shift_ir) begin
            tdo_d = ir_sh_q[0];
        end else if (sel_chain) begin
            tdo_d = chain_q[CHAIN_W-1];
        end else begin
            tdo_d = bypass_q; // [RULE23]
        end
    end

    // Output retimed on falling edge so the host sees stable data at rise
    always_ff @(negedge TCK) begin
        if (!trst_n_q) begin
            TDO <= 1'b0;
        end else begin
            TDO <= tdo_d; // [RULE17]
        end
    end

    // Enable follows the shift states, also on the falling edge
    always_ff @(negedge TCK) begin
        if (!trst_n_q) begin
            TDO_OE <= 1'b0;
        end else begin
            TDO_OE <= ctrl.shift_ir || !ctrl.shift_dr_n; // [RULE17]
        end
    end

    // Pad drive: mux is unavoidable so normal mode has no added latency
    // Limitation: pads follow mode through gates, not an output flop
    for (genvar k = 0; k < NUM_PADS; k++) begin : g_drive
        assign PAD_OUT[k] = mode ? upd_q[k * `BST_CELLS_PER_PAD + `BST_DATA_CELL] // [RULE14]
                                 : CORE_OUT[k]; // [RULE7] [RULE15]
        assign PAD_OE[k] = mode ? upd_q[k * `BST_CELLS_PER_PAD + `BST_DIR_CELL] // [RULE14]
                                : CORE_OE[k]; // [RULE7] [RULE15]
    end

    // Pad inputs to the array, synchronised to the system clock
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pin_r1_q <= '0;
            pin_r2_q <= '0;
            CORE_IN <= '0;
        end else begin
            pin_r1_q <= PAD_IN;
            pin_r2_q <= pin_r1_q;
            CORE_IN <= pin_r2_q; // [RULE7]
        end
    end

    // Mode level crossed into the system clock for status
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mode_r1_q <= 1'b0;
            mode_r2_q <= 1'b0;
            TEST_MODE <= 1'b0;
        end else begin
            mode_r1_q <= mode;
            mode_r2_q <= mode_r1_q;
            TEST_MODE <= mode_r2_q;
        end
    end

endmodule

// ### verification/bst_test_host.sv
`timescale 1ns/1ps
// Scan host model driving the test port around its own stopped clock
module bst_test_host (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Clock idles low between steps
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 32 ns test clock period; inputs move while the clock is low
    // Faster than a board host may run; the zero-delay model has no rate limit
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #16;
        o = tdo_oe ? tdo : ~tdo; // Released line reads as the opposite level
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask

    // Idle to idle scan; the instruction path shifts its low bit first
    task automatic scan(input logic ir_path, input int n, input logic [7:0] vin,
                        output logic [7:0] vout);
        logic o;
        int idx;
        vout = 8'h00;
        step(1'b1, 1'b0, o);
        if (ir_path) begin
            step(1'b1, 1'b0, o);
        end
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int k = 0; k < n; k++) begin
            idx = ir_path ? k : n - 1 - k;
            step(k == n - 1, vin[idx], o);
            vout[idx] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule

// ### verification/bst_boundary_scan_props.sv
`timescale 1ns/1ps
// Port-level checks of the boundary scan block
module bst_boundary_scan_props #(
    parameter int NUM_PADS = 4
) (
    // Clocks and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic TCK,
    // Test port
    input wire logic TMS,
    input wire logic TDO,
    input wire logic TDO_OE,
    // Pads and array
    input wire logic [NUM_PADS-1:0] PAD_IN,
    input wire logic [NUM_PADS-1:0] PAD_OUT,
    input wire logic [NUM_PADS-1:0] PAD_OE,
    input wire logic [NUM_PADS-1:0] CORE_OUT,
    input wire logic [NUM_PADS-1:0] CORE_OE,
    input wire logic [NUM_PADS-1:0] CORE_IN,
    input wire logic TEST_MODE
);
    // Mode flag lags by about three cycles, so look four back
    property p_func_pads;
        @(posedge REF_CLK) disable iff (!RST_N)
        (!TEST_MODE)[*3] |-> $past({PAD_OUT, PAD_OE}, 4) == $past({CORE_OUT, CORE_OE}, 4);
    endproperty
    property p_core_in;
        @(posedge REF_CLK) disable iff (!RST_N)
        RST_N[*5] |-> CORE_IN == $past(PAD_IN, 3);
    endproperty
    // Nothing test-clocked may move while the test clock stays high
    property p_tdo_fall;
        @(posedge REF_CLK) disable iff (!RST_N)
        TCK && $past(TCK) |-> $stable({TDO, TDO_OE});
    endproperty
    property p_pad_fall;
        @(posedge REF_CLK) disable iff (!RST_N)
        TCK && $past(TCK) && $stable({CORE_OUT, CORE_OE}) |-> $stable({PAD_OUT, PAD_OE});
    endproperty
    // Shift state walk and held update flops
    property p_hold_shift;
        @(posedge TCK) disable iff (!RST_N)
        TDO_OE && $past(TDO_OE) && TEST_MODE |-> $stable({PAD_OUT, PAD_OE});
    endproperty
    property p_exit_shift;
        @(posedge TCK) disable iff (!RST_N)
        TDO_OE && TMS |=> !TDO_OE;
    endproperty
    property p_stay_shift;
        @(posedge TCK) disable iff (!RST_N)
        TDO_OE && !TMS |=> TDO_OE;
    endproperty
    property p_five_ones;
        @(posedge TCK) disable iff (!RST_N)
        TMS[*5] |=> !TDO_OE && PAD_OUT == CORE_OUT && PAD_OE == CORE_OE;
    endproperty

    a_func_pads: assert property (p_func_pads) else $error("pads not functional");
    a_core_in: assert property (p_core_in) else $error("array input delay wrong");
    a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved on rise");
    a_pad_fall: assert property (p_pad_fall) else $error("pad moved on rise");
    a_hold_shift: assert property (p_hold_shift) else $error("pads moved in shift");
    a_exit_shift: assert property (p_exit_shift) else $error("shift not left");
    a_stay_shift: assert property (p_stay_shift) else $error("shift left early");
    a_five_ones: assert property (p_five_ones) else $error("no reset on ones");

    // Main scenarios reached
    c_extest: cover property (@(posedge REF_CLK) $rose(TEST_MODE));
    c_shift_exit: cover property (@(posedge TCK) TDO_OE && TMS);
    c_core_move: cover property (@(posedge REF_CLK) TEST_MODE && $changed(CORE_OUT));
endmodule

bind bst_boundary_scan bst_boundary_scan_props #(.NUM_PADS(NUM_PADS)) bst_props_inst (
    .REF_CLK, .RST_N, .TCK, .TMS, .TDO, .TDO_OE, .PAD_IN, .PAD_OUT, .PAD_OE,
    .CORE_OUT, .CORE_OE, .CORE_IN, .TEST_MODE
);

// ### verification/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the boundary scan block
module testbench;
    logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, test_mode, o;
    logic [3:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
    logic [7:0] got;
    int error_cnt = 0;
    int cmp_count = 0;

    bst_boundary_scan bst_boundary_scan_inst (
        .REF_CLK(ref_clk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE(tdo_oe), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
        .CORE_OUT(core_out), .CORE_OE(core_oe), .CORE_IN(core_in), .TEST_MODE(test_mode)
    );
    bst_test_host bst_test_host_inst (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    // System clock, 5 ns
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Captured chain: direction cell above data cell for each pad
    function automatic logic [7:0] chain(input logic [3:0] oe, input logic [3:0] dat,
                                         input logic [3:0] pin);
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v[2*k+1] = oe[k];
            v[2*k] = oe[k] ? dat[k] : pin[k];
        end
        return v;
    endfunction

    // Reset needs the test clock running to reach its domain
    task automatic t_reset();
        repeat (4) bst_test_host_inst.step(1'b1, 1'b0, o);
        @(posedge ref_clk) #1;
        rst_n = 1'b1;
        repeat (2) bst_test_host_inst.step(1'b1, 1'b0, o);
        check("reset pads", {pad_out, pad_oe}, {core_out, core_oe});
        check("reset port", {6'h00, tdo_oe, test_mode}, 8'h00);
        bst_test_host_inst.step(1'b0, 1'b0, o);
    endtask

    // Bypass and every vendor code give a one-flop path
    task automatic t_bypass();
        logic [2:0] codes [6] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
        foreach (codes[i]) begin
            bst_test_host_inst.scan(1'b1, 3, {5'h00, codes[i]}, got);
            check("ir capture", got, 8'h01);
            bst_test_host_inst.scan(1'b0, 4, 8'h0b, got);
            check("bypass out", got, 8'h05);
        end
    endtask

    // Sample observes pads, then preloads the update flops
    task automatic t_sample();
        bst_test_host_inst.scan(1'b1, 3, 8'h04, got);
        bst_test_host_inst.scan(1'b0, 8, 8'h9c, got);
        check("sample chain", got, chain(core_oe, core_out, pad_in));
        check("sample pads", {pad_out, pad_oe}, {core_out, core_oe});
        check("sample mode", {7'h00, test_mode}, 8'h00);
    endtask

    // External test drives held data and ignores the array
    task automatic t_extest();
        bst_test_host_inst.scan(1'b1, 3, 8'h00, got);
        check("preload pads", {pad_out, pad_oe}, 8'h6a);
        bst_test_host_inst.scan(1'b0, 8, 8'h63, got);
        check("extest chain", got, chain(4'ha, 4'h6, pad_in));
        check("update pads", {pad_out, pad_oe}, 8'h95);
        check("extest mode", {7'h00, test_mode}, 8'h01);
        @(posedge ref_clk) #1;
        core_out = 4'h9;
        core_oe = 4'hc;
        pad_in = 4'h5;
        repeat (4) @(posedge ref_clk);
        #1;
        check("array ignored", {pad_out, pad_oe}, 8'h95);
        check("array input", {core_in, 4'h0}, {pad_in, 4'h0});
    endtask

    // Five ones return the pads to the array; a sixth lets the checker see it
    task automatic t_leave();
        repeat (6) bst_test_host_inst.step(1'b1, 1'b0, o);
        repeat (4) @(posedge ref_clk);
        #1;
        check("leave pads", {pad_out, pad_oe}, {core_out, core_oe});
        check("leave mode", {7'h00, test_mode}, 8'h00);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        core_out = 4'h6;
        core_oe = 4'h3;
        pad_in = 4'ha;
        t_reset();
        t_bypass();
        t_sample();
        t_extest();
        t_leave();
        conclude();
    end

    // Watchdog far beyond the few microseconds the run needs
    initial begin
        #50000;
        error_cnt++;
        conclude();
    end
endmodule
